// ===== seq_pkg.sv
`default_nettype none
package seq_pkg;
  localparam int CLK_MHZ = 125;
  localparam int CLK_PERIOD_PS = 8000;
  // delay timer unit: 0.5 ms
  localparam int DELAY_STEP_US = 500;
  localparam int DELAY_STEP_CYC = DELAY_STEP_US * CLK_MHZ;
  // one 6.25 mV step at the slowest slew of 0.1 V/ms
  localparam int SLEW_STEP_PS = 62500000;
  localparam int SLEW_BASE_CYC = SLEW_STEP_PS / CLK_PERIOD_PS;
  // power-good masking time, no figure given
  localparam int PG_MASK_US = 100;
  localparam int PG_MASK_CYC = PG_MASK_US * CLK_MHZ;
  // master clock tick stands in for the oscillator rate
  localparam logic [7:0] MCLK_DIV = 8'h10;
  localparam logic [2:0] DETECT_TICKS = 3'h6;
  localparam logic [2:0] DELAY_RST = 3'h3;
  localparam logic [2:0] SLEW_RST = 3'h2;
  localparam logic [7:0] CMD_DELAY = 8'hd4;
  localparam logic [7:0] CMD_SLEW = 8'hd5;
  localparam logic [7:0] CMD_STATUS = 8'hd6;
  // serial bus address, arbitrary value
  localparam logic [6:0] DEV_ADDR = 7'h20;
  // 1.1 V in 6.25 mV steps
  localparam logic [7:0] BOOT_CODE = 8'hb0;
  localparam logic [2:0] PHASES_MAX = 3'h4;
  typedef logic [7:0] code_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_DELAY = 4'h1, ST_DETECT = 4'h2, ST_BOOT = 4'h3,
    ST_HOLD = 4'h4, ST_FINAL = 4'h5, ST_MASK = 4'h6, ST_BLANK = 4'h7,
    ST_RUN = 4'h8, ST_LATCH = 4'h9
  } seq_t;
  typedef enum logic [3:0] {
    BI_IDLE = 4'h0, BI_ADDR = 4'h1, BI_ACKA = 4'h2, BI_CMD = 4'h3,
    BI_ACKC = 4'h4, BI_DATA = 4'h5, BI_ACKD = 4'h6, BI_READ = 4'h7,
    BI_RACK = 4'h8
  } bus_t;
endpackage : seq_pkg
`default_nettype wire

// ===== seq_timer.sv
`timescale 1ns/1ps
`default_nettype none
module seq_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // request
  input wire logic start_i,
  input wire logic [16:0] len_i,
  input wire logic [5:0] units_i,
  // answer
  output logic done_o
);
  logic busy_ff;
  logic [16:0] len_ff;
  logic [16:0] cyc_ff;
  logic [5:0] left_ff;

  // a new start restarts; settings are taken only here
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      busy_ff <= 1'b0;
      len_ff <= 17'h0;
      cyc_ff <= 17'h0;
      left_ff <= 6'h0;
      done_o <= 1'b0;
    end
    else if (start_i)
    begin
      busy_ff <= 1'b1;
      len_ff <= len_i;
      cyc_ff <= len_i - 17'h1;
      left_ff <= units_i - 6'h1;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (busy_ff && cyc_ff == 17'h0)
      begin
        if (left_ff == 6'h0)
        begin
          busy_ff <= 1'b0;
          done_o <= 1'b1;
        end
        else
        begin
          left_ff <= left_ff - 6'h1;
          cyc_ff <= len_ff - 17'h1;
        end
      end
      else if (busy_ff)
        cyc_ff <= cyc_ff - 17'h1;
    end
  end
endmodule : seq_timer
`default_nettype wire

// ===== phase_chan.sv
`timescale 1ns/1ps
`default_nettype none
module phase_chan (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // control
  input wire logic en_i,
  input wire logic tick_i,
  input wire logic trip_i,
  // pin
  output logic pwm_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // own turn beats the trip so duty can reach a full period
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !en_i)
      pwm_o <= 1'b0;
    else if (tick_i)
      pwm_o <= 1'b1;
    else if (trip_i)
      pwm_o <= 1'b0;
  end

  AST_CHAN_TURN: assert property ((en_i && tick_i) |=> pwm_o)
    else $error("phase did not start on its turn");
endmodule : phase_chan
`default_nettype wire

// ===== startup_seq.sv
`timescale 1ns/1ps
`default_nettype none
module startup_seq #(
  parameter int DELAY_UNIT_CYC = seq_pkg::DELAY_STEP_CYC,
  parameter int SLEW_BASE_CYC = seq_pkg::SLEW_BASE_CYC,
  parameter int PG_MASK_CYC = seq_pkg::PG_MASK_CYC
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // control pins
  input wire logic ENABLE_I,
  input wire logic SUPPLY_OK_I,
  input wire logic CURRENT_LIMIT_I,
  input wire seq_pkg::code_t VOLTAGE_CODE_I,
  // phase pins
  input wire logic [2:0] PHASE_SENSE_I,
  input wire logic [3:0] PHASE_TRIP_I,
  output logic [3:0] PHASE_OUT_O,
  output logic [3:0] PHASE_OE_O,
  output logic [2:0] SINK_EN_O,
  // regulator status
  output seq_pkg::code_t SETPOINT_CODE_O,
  output logic [2:0] PHASE_COUNT_O,
  output logic POWER_GOOD_O,
  output logic LATCHOFF_O,
  // serial bus
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O
);
  import seq_pkg::*;

  logic [19:0] raw;
  logic [19:0] s1_ff;
  logic [19:0] s2_ff;
  logic ena_s, sup_s, lim_s, scl_s, sda_s;
  logic [2:0] sense_s;
  logic [3:0] trip_s;
  code_t vid_s;
  seq_t st_ff;
  bus_t bs_ff;
  logic [2:0] dly_ff;
  logic [2:0] slew_ff;
  code_t sp_ff;
  code_t tgt_ff;
  code_t aim;
  code_t rd;
  logic [3:0] act_ff;
  logic [2:0] cnt_ff;
  logic [2:0] det_ff;
  logic [7:0] mdiv_ff;
  logic mtick_ff;
  logic [1:0] ptr_ff;
  logic [3:0] ptick_ff;
  logic t0_start_ff, t0_done, sarm_ff, lim_run_ff;
  logic [16:0] t0_len_ff;
  logic [16:0] t1_len_ff;
  logic [5:0] t0_units_ff;
  logic [5:0] dly_units;
  logic go, ramp, pre, post, pwm_en;
  logic scl_d_ff, sda_d_ff, rise, fall, bus_start, bus_stop;
  logic [7:0] sh_ff;
  logic [7:0] cmd_ff;
  logic [7:0] byte_in;
  logic [2:0] bc_ff;
  logic rw_ff, ackon_ff;

  // voltage code is multi-bit but only sampled after it has settled
  assign raw = {ENABLE_I, SUPPLY_OK_I, CURRENT_LIMIT_I, PHASE_SENSE_I,
                VOLTAGE_CODE_I, PHASE_TRIP_I, SCL_I, SDA_I};
  always_ff @(posedge CLK_I)
  begin
    s1_ff <= raw;
    s2_ff <= s1_ff;
  end
  assign {ena_s, sup_s, lim_s, sense_s, vid_s, trip_s, scl_s, sda_s} = s2_ff;

  assign go = ena_s && sup_s;
  assign dly_units = {3'h0, dly_ff} + 6'h1;
  assign ramp = (st_ff == ST_BOOT) || (st_ff == ST_FINAL);
  assign aim = (st_ff == ST_BOOT) ? BOOT_CODE : tgt_ff;
  assign pre = st_ff inside {ST_IDLE, ST_DELAY, ST_DETECT};
  assign post = !pre;
  assign pwm_en = st_ff inside {ST_BOOT, ST_HOLD, ST_FINAL, ST_MASK, ST_BLANK, ST_RUN};

  function automatic logic [16:0] slew_len(input logic [2:0] code);
    slew_len = 17'(SLEW_BASE_CYC / (2 * int'(code) + 1));
  endfunction : slew_len

  // startup sequence
  always_ff @(posedge CLK_I)
  begin
    t0_start_ff <= 1'b0;
    if (SRST_I)
    begin
      st_ff <= ST_IDLE;
      t0_len_ff <= 17'h0;
      t0_units_ff <= 6'h0;
      tgt_ff <= 8'h00;
      lim_run_ff <= 1'b0;
    end
    else if (!go && st_ff != ST_IDLE)
    begin
      // dropping enable also clears a latchoff
      st_ff <= ST_IDLE;
      lim_run_ff <= 1'b0;
    end
    else
    begin
      unique case (st_ff)
        ST_IDLE:
          if (go)
          begin
            st_ff <= ST_DELAY;
            t0_start_ff <= 1'b1;
            t0_units_ff <= dly_units;
            t0_len_ff <= 17'(DELAY_UNIT_CYC);
          end
        ST_DELAY:
          if (t0_done)
            st_ff <= ST_DETECT;
        ST_DETECT:
          if (det_ff == DETECT_TICKS)
            st_ff <= ST_BOOT;
        ST_BOOT:
          if (sp_ff == BOOT_CODE)
          begin
            st_ff <= ST_HOLD;
            t0_start_ff <= 1'b1;
            t0_units_ff <= dly_units;
            t0_len_ff <= 17'(DELAY_UNIT_CYC);
          end
        ST_HOLD:
          if (t0_done)
          begin
            st_ff <= ST_FINAL;
            tgt_ff <= vid_s;
          end
        ST_FINAL:
          if (sp_ff == tgt_ff)
          begin
            st_ff <= ST_MASK;
            t0_start_ff <= 1'b1;
            t0_units_ff <= 6'h1;
            t0_len_ff <= 17'(PG_MASK_CYC);
          end
        ST_MASK:
          if (t0_done)
          begin
            st_ff <= ST_BLANK;
            t0_start_ff <= 1'b1;
            t0_units_ff <= dly_units;
            t0_len_ff <= 17'(DELAY_UNIT_CYC);
          end
        ST_BLANK:
          if (t0_done)
            st_ff <= ST_RUN;
        ST_RUN:
          if (lim_s && !lim_run_ff)
          begin
            lim_run_ff <= 1'b1;
            t0_start_ff <= 1'b1;
            t0_units_ff <= {dly_units[3:0], 2'h0};
            t0_len_ff <= 17'(DELAY_UNIT_CYC);
          end
          else if (!lim_s && lim_run_ff)
            lim_run_ff <= 1'b0;
          else if (lim_run_ff && t0_done)
            st_ff <= ST_LATCH;
        ST_LATCH:
        begin
        end
        default:
          st_ff <= ST_IDLE;
      endcase
    end
  end

  seq_timer u_delay (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .start_i(t0_start_ff),
    .len_i(t0_len_ff),
    .units_i(t0_units_ff),
    .done_o(t0_done)
  );

  // ramp stepping; slew is re-read at each step
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I || st_ff == ST_IDLE)
    begin
      sp_ff <= 8'h00;
      sarm_ff <= 1'b0;
      t1_len_ff <= 17'h0;
    end
    else if (ramp && sp_ff != aim)
    begin
      if (!sarm_ff)
      begin
        sarm_ff <= 1'b1;
        t1_len_ff <= slew_len(slew_ff) - 17'h1;
      end
      else if (t1_len_ff == 17'h0)
      begin
        // reload on the step itself, so a step period has no dead cycles
        t1_len_ff <= slew_len(slew_ff) - 17'h1;
        sp_ff <= (sp_ff < aim) ? sp_ff + 8'h1 : sp_ff - 8'h1;
      end
      else
        t1_len_ff <= t1_len_ff - 17'h1;
    end
    else
      sarm_ff <= 1'b0;
  end

  // master clock and phase rotation
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I || mdiv_ff == MCLK_DIV - 8'h1)
      mdiv_ff <= 8'h00;
    else
      mdiv_ff <= mdiv_ff + 8'h1;
    mtick_ff <= !SRST_I && (mdiv_ff == MCLK_DIV - 8'h1);
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      ptr_ff <= 2'h0;
      ptick_ff <= 4'h0;
    end
    else
    begin
      ptick_ff <= mtick_ff ? (4'h1 << ptr_ff) : 4'h0;
      if (mtick_ff)
        ptr_ff <= ({1'b0, ptr_ff} == cnt_ff - 3'h1) ? 2'h0 : ptr_ff + 2'h1;
    end
  end

  // phase detection over six master ticks after the delay, before the ramp starts
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I || st_ff != ST_DETECT)
      det_ff <= 3'h0;
    else if (mtick_ff && det_ff != DETECT_TICKS)
      det_ff <= det_ff + 3'h1;
  end

  // odd strappings fall back to all phases
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      act_ff <= 4'hf;
      cnt_ff <= PHASES_MAX;
    end
    else if (st_ff == ST_DETECT && det_ff == DETECT_TICKS)
    begin
      unique case (sense_s)
        3'h4:
        begin
          act_ff <= 4'h7;
          cnt_ff <= 3'h3;
        end
        3'h6:
        begin
          act_ff <= 4'h3;
          cnt_ff <= 3'h2;
        end
        3'h7:
        begin
          act_ff <= 4'h1;
          cnt_ff <= 3'h1;
        end
        default:
        begin
          act_ff <= 4'hf;
          cnt_ff <= PHASES_MAX;
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_phase
      phase_chan u_chan (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .en_i(pwm_en && act_ff[g]),
        .tick_i(ptick_ff[g]),
        .trip_i(trip_s[g]),
        .pwm_o(PHASE_OUT_O[g])
      );
    end
  endgenerate

  // pin drive and status
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      PHASE_OE_O <= 4'h1;
      SINK_EN_O <= 3'h0;
      SETPOINT_CODE_O <= 8'h00;
      PHASE_COUNT_O <= PHASES_MAX;
      POWER_GOOD_O <= 1'b0;
      LATCHOFF_O <= 1'b0;
    end
    else
    begin
      PHASE_OE_O <= {post ? act_ff[3:1] : 3'h0, 1'b1};
      SINK_EN_O <= (ena_s && pre) ? 3'h7 : 3'h0;
      SETPOINT_CODE_O <= sp_ff;
      PHASE_COUNT_O <= cnt_ff;
      POWER_GOOD_O <= (st_ff == ST_RUN);
      LATCHOFF_O <= (st_ff == ST_LATCH);
    end
  end

  // serial bus slave
  assign SDA_O = 1'b0;
  assign rise = scl_s && !scl_d_ff;
  assign fall = !scl_s && scl_d_ff;
  assign bus_start = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign bus_stop = scl_s && scl_d_ff && !sda_d_ff && sda_s;
  assign byte_in = {sh_ff[6:0], sda_s};

  always_comb
  begin
    unique case (cmd_ff)
      CMD_DELAY: rd = {5'h00, dly_ff};
      CMD_SLEW: rd = {5'h00, slew_ff};
      CMD_STATUS: rd = {st_ff, cnt_ff[1:0] - 2'h1, LATCHOFF_O, POWER_GOOD_O};
      default: rd = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    scl_d_ff <= SRST_I || scl_s;
    sda_d_ff <= SRST_I || sda_s;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      bs_ff <= BI_IDLE;
      sh_ff <= 8'h00;
      cmd_ff <= 8'h00;
      bc_ff <= 3'h0;
      rw_ff <= 1'b0;
      ackon_ff <= 1'b0;
      SDA_OE_O <= 1'b0;
      dly_ff <= DELAY_RST;
      slew_ff <= SLEW_RST;
    end
    else if (bus_start)
    begin
      bs_ff <= BI_ADDR;
      bc_ff <= 3'h0;
      SDA_OE_O <= 1'b0;
    end
    else if (bus_stop)
    begin
      bs_ff <= BI_IDLE;
      SDA_OE_O <= 1'b0;
    end
    else
    begin
      unique case (bs_ff)
        BI_IDLE:
        begin
        end
        BI_ADDR, BI_CMD, BI_DATA:
          if (rise)
          begin
            sh_ff <= byte_in;
            bc_ff <= bc_ff + 3'h1;
            ackon_ff <= 1'b0;
            if (bc_ff == 3'h7 && bs_ff == BI_ADDR)
            begin
              rw_ff <= sda_s;
              bs_ff <= (byte_in[7:1] == DEV_ADDR) ? BI_ACKA : BI_IDLE;
            end
            else if (bc_ff == 3'h7 && bs_ff == BI_CMD)
            begin
              cmd_ff <= byte_in;
              bs_ff <= BI_ACKC;
            end
            else if (bc_ff == 3'h7)
            begin
              if (cmd_ff == CMD_DELAY)
                dly_ff <= byte_in[2:0];
              if (cmd_ff == CMD_SLEW)
                slew_ff <= byte_in[2:0];
              bs_ff <= BI_ACKD;
            end
          end
        BI_ACKA, BI_ACKC, BI_ACKD:
          if (fall)
          begin
            ackon_ff <= !ackon_ff;
            SDA_OE_O <= !ackon_ff;
            if (ackon_ff && bs_ff == BI_ACKA && rw_ff)
            begin
              sh_ff <= rd;
              SDA_OE_O <= !rd[7];
              bs_ff <= BI_READ;
            end
            else if (ackon_ff)
              bs_ff <= (bs_ff == BI_ACKA) ? BI_CMD : BI_DATA;
          end
        BI_READ:
          if (fall)
            SDA_OE_O <= !sh_ff[7];
          else if (rise)
          begin
            sh_ff <= {sh_ff[6:0], 1'b0};
            bc_ff <= bc_ff + 3'h1;
            if (bc_ff == 3'h7)
              bs_ff <= BI_RACK;
          end
        BI_RACK:
          if (fall)
            SDA_OE_O <= 1'b0;
          else if (rise && sda_s)
            bs_ff <= BI_IDLE;
          else if (rise)
          begin
            sh_ff <= rd;
            bs_ff <= BI_READ;
          end
        default:
          bs_ff <= BI_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  sequence hold_to_final;
    st_ff == ST_HOLD ##1 st_ff == ST_FINAL;
  endsequence
  sequence mask_to_blank;
    st_ff == ST_MASK ##1 st_ff == ST_BLANK;
  endsequence

  AST_START_GATE: assert property ((st_ff == ST_IDLE ##1 st_ff == ST_DELAY) |-> $past(go))
    else $error("initial delay began without enable and supply");
  AST_DETECT_QUIET: assert property (st_ff == ST_DETECT |=> PHASE_OUT_O == 4'h0 && PHASE_OE_O[0])
    else $error("phase output active during detection");
  AST_BOOT_LEVEL: assert property ((st_ff == ST_BOOT ##1 st_ff == ST_HOLD) |-> sp_ff == 8'hb0)
    else $error("boot hold entered away from boot code");
  AST_HOLD_UNITS: assert property ((t0_start_ff && st_ff == ST_HOLD) |-> t0_units_ff == dly_units)
    else $error("boot hold length wrong");
  AST_VID_SAMPLE: assert property (hold_to_final |-> tgt_ff == $past(vid_s))
    else $error("target not sampled at end of hold");
  AST_BLANK_START: assert property (mask_to_blank |-> $past(t0_done) ##1 t0_start_ff == 1'b0)
    else $error("blanking began before mask time ended");
  AST_LATCH_LEN: assert property ((t0_start_ff && st_ff == ST_RUN) |-> t0_units_ff == {dly_units[3:0], 2'h0})
    else $error("latchoff not four delays");
  AST_RESET_CODES: assert property ($fell(SRST_I) |-> dly_ff == 3'h3 && slew_ff == 3'h2)
    else $error("codes wrong after reset");
  AST_STEP: assert property ((ramp && $changed(sp_ff)) |-> (sp_ff == $past(sp_ff) + 8'h1) || (sp_ff == $past(sp_ff) - 8'h1))
    else $error("setpoint moved by more than one step");
  AST_RAMP_ORDER: assert property ($rose(st_ff == ST_BOOT) |-> $past(st_ff) == ST_DETECT && $past(det_ff) == 3'h6)
    else $error("ramp began before detection");
  AST_FLOAT: assert property ((post && !act_ff[3]) |=> !PHASE_OE_O[3])
    else $error("strapped phase still driven");
endmodule : startup_seq
`default_nettype wire

// ===== bus_host.sv
`timescale 1ns/1ps
`default_nettype none
module bus_host (
  // clock
  input wire logic clk_i,
  // bus lines
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  import seq_pkg::*;
  // slow scl, the design syncs both lines at the system clock
  localparam int HALF = 20;
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic hold();
    repeat (HALF) @(negedge clk_i);
  endtask : hold
  // one bit; a released line reads what the device drives
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = ~b;
    hold();
    scl_o = 1'b1;
    hold();
    r = sda_i;
    scl_o = 1'b0;
  endtask : bit_io
  // serves as repeated start too
  task automatic start();
    sda_low_o = 1'b0;
    hold();
    scl_o = 1'b1;
    hold();
    sda_low_o = 1'b1;
    hold();
    scl_o = 1'b0;
  endtask : start
  task automatic stop();
    sda_low_o = 1'b1;
    hold();
    scl_o = 1'b1;
    hold();
    sda_low_o = 1'b0;
    hold();
  endtask : stop
  task automatic xfer(input code_t v, input logic ack_in, output code_t r, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], r[i]);
    bit_io(ack_in, ack);
  endtask : xfer
  task automatic wr(input logic [6:0] dev, input code_t cmd, input code_t d, output logic ok);
    code_t r;
    logic a0;
    logic a1;
    logic a2;
    start();
    xfer({dev, 1'b0}, 1'b1, r, a0);
    xfer(cmd, 1'b1, r, a1);
    xfer(d, 1'b1, r, a2);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask : wr
  // single byte read, nack ends it
  task automatic rd(input code_t cmd, output code_t d);
    code_t r;
    logic a;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r, a);
    xfer(cmd, 1'b1, r, a);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, r, a);
    xfer(8'hff, 1'b1, d, a);
    stop();
  endtask : rd
endmodule : bus_host
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import seq_pkg::*;
  localparam int DU = 50;
  localparam int PGM = 20;
  logic CLK_I, SRST_I, ENABLE_I, SUPPLY_OK_I, CURRENT_LIMIT_I, scl, host_low;
  code_t VOLTAGE_CODE_I, SETPOINT_CODE_O;
  logic [2:0] PHASE_SENSE_I, SINK_EN_O, PHASE_COUNT_O;
  logic [3:0] PHASE_TRIP_I, PHASE_OUT_O, PHASE_OE_O;
  logic POWER_GOOD_O, LATCHOFF_O, SDA_O, SDA_OE_O;
  wire logic sda;
  int n_fail = 0;
  int check_count = 0;
  // open drain with pull-up
  assign sda = ~(host_low | (SDA_OE_O & ~SDA_O));
  startup_seq #(.DELAY_UNIT_CYC(DU), .SLEW_BASE_CYC(30), .PG_MASK_CYC(PGM)) dut (
    .CLK_I(CLK_I), .SRST_I(SRST_I), .ENABLE_I(ENABLE_I), .SUPPLY_OK_I(SUPPLY_OK_I),
    .CURRENT_LIMIT_I(CURRENT_LIMIT_I), .VOLTAGE_CODE_I(VOLTAGE_CODE_I),
    .PHASE_SENSE_I(PHASE_SENSE_I), .PHASE_TRIP_I(PHASE_TRIP_I), .PHASE_OUT_O(PHASE_OUT_O),
    .PHASE_OE_O(PHASE_OE_O), .SINK_EN_O(SINK_EN_O), .SETPOINT_CODE_O(SETPOINT_CODE_O),
    .PHASE_COUNT_O(PHASE_COUNT_O), .POWER_GOOD_O(POWER_GOOD_O), .LATCHOFF_O(LATCHOFF_O),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O));
  bus_host host (.clk_i(CLK_I), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input code_t exp, input code_t got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK_I);
  endtask : cyc
  // cycles from enable to the first setpoint step
  task automatic power_up(output int t);
    int loud;
    loud = 0;
    ENABLE_I = 1'b1;
    for (t = 0; t < 3000 && SETPOINT_CODE_O === 8'h00; t++)
    begin
      @(negedge CLK_I);
      if (PHASE_OUT_O !== 4'h0)
        loud++;
      if (t == 20)
        chk("sink", 8'h07, {5'h0, SINK_EN_O});
    end
    chk_rng("quiet", 0, 0, loud);
  endtask : power_up
  // follows a ramp; returns the wait before its first step
  task automatic ramp_to(input code_t tgt, input int gap, output int first);
    code_t prev;
    int since;
    int bad;
    prev = SETPOINT_CODE_O;
    since = 0;
    bad = 0;
    first = -1;
    for (int n = 0; n < 3000 && SETPOINT_CODE_O !== tgt; n++)
    begin
      @(negedge CLK_I);
      since++;
      if (SETPOINT_CODE_O !== prev)
      begin
        if (SETPOINT_CODE_O !== prev + 8'h01 && SETPOINT_CODE_O !== prev - 8'h01)
          bad++;
        if (first < 0)
          first = since;
        else if (since != gap)
          bad++;
        prev = SETPOINT_CODE_O;
        since = 0;
      end
    end
    chk("ramp end", tgt, SETPOINT_CODE_O);
    chk_rng("ramp steps", 0, 0, bad);
  endtask : ramp_to
  task automatic t_regs();
    code_t d;
    logic ok;
    host.rd(CMD_DELAY, d);
    chk("delay reset", 8'h03, d);
    host.rd(CMD_SLEW, d);
    chk("slew reset", 8'h02, d);
    chk("count reset", 8'h04, {5'h0, PHASE_COUNT_O});
    host.wr(DEV_ADDR, CMD_SLEW, 8'hfd, ok);
    host.rd(CMD_SLEW, d);
    chk("slew write", 8'h05, d);
    host.wr(DEV_ADDR ^ 7'h01, CMD_DELAY, 8'h00, ok);
    chk("foreign ack", 8'h00, {7'h0, ok});
    host.wr(DEV_ADDR, CMD_STATUS, 8'hff, ok);
    host.rd(CMD_DELAY, d);
    chk("delay kept", 8'h03, d);
    host.wr(DEV_ADDR, CMD_SLEW, 8'h02, ok);
  endtask : t_regs
  task automatic t_straps();
    logic ok;
    logic [2:0] c;
    int t;
    int lo;
    for (int i = 0; i < 4; i++)
    begin
      c = (i == 1) ? 3'h7 : 3'h0;
      host.wr(DEV_ADDR, CMD_DELAY, {5'h0, c}, ok);
      PHASE_SENSE_I = 3'h7 << (3 - i);
      power_up(t);
      lo = (c + 1) * DU + 95;
      chk_rng("first step", lo, lo + 20, t);
      chk("count", 8'(4 - i), {5'h0, PHASE_COUNT_O});
      chk("drive", 8'(4'hf >> i), {4'h0, PHASE_OE_O});
      chk("sink off", 8'h00, {5'h0, SINK_EN_O});
      if (i % 2 == 1)
        SUPPLY_OK_I = 1'b0;
      else
        ENABLE_I = 1'b0;
      cyc(8);
      chk("dropped", 8'h00, SETPOINT_CODE_O);
      ENABLE_I = 1'b0;
      cyc(2);
      SUPPLY_OK_I = 1'b1;
    end
  endtask : t_straps
  task automatic t_sequence();
    logic ok;
    int t;
    host.wr(DEV_ADDR, CMD_DELAY, 8'h01, ok);
    PHASE_SENSE_I = 3'h6;
    VOLTAGE_CODE_I = 8'h90;
    power_up(t);
    ramp_to(BOOT_CODE, 6, t);
    ramp_to(8'h90, 6, t);
    chk_rng("hold", 2 * DU, 2 * DU + 30, t);
    for (t = 0; t < 1000 && POWER_GOOD_O !== 1'b1; t++)
      @(negedge CLK_I);
    chk_rng("good", PGM + 2 * DU, PGM + 2 * DU + 20, t);
  endtask : t_sequence
  task automatic t_run();
    code_t d;
    logic [3:0] last;
    int r0;
    int r1;
    int t;
    r0 = 0;
    r1 = 0;
    last = PHASE_OUT_O;
    repeat (320)
    begin
      @(negedge CLK_I);
      r0 += int'(PHASE_OUT_O[0] & ~last[0]);
      r1 += int'(PHASE_OUT_O[1] & ~last[1]);
      last = PHASE_OUT_O;
    end
    chk_rng("rate one", 9, 11, r0);
    chk_rng("rate two", 9, 11, r1);
    // no trip: both active phases stay up together, the floated ones stay low
    PHASE_TRIP_I = 4'h0;
    cyc(40);
    chk("overlap", 8'h03, {4'h0, PHASE_OUT_O});
    PHASE_TRIP_I = 4'hf;
    cyc(40);
    // a short fault must not latch
    CURRENT_LIMIT_I = 1'b1;
    cyc(200);
    CURRENT_LIMIT_I = 1'b0;
    cyc(300);
    chk("no latch", 8'h00, {7'h0, LATCHOFF_O});
    CURRENT_LIMIT_I = 1'b1;
    for (t = 0; t < 1000 && LATCHOFF_O !== 1'b1; t++)
      @(negedge CLK_I);
    chk_rng("latchoff", 8 * DU, 8 * DU + 10, t);
    cyc(2);
    chk("good off", 8'h00, {7'h0, POWER_GOOD_O});
    chk("outs off", 8'h00, {4'h0, PHASE_OUT_O});
    host.rd(CMD_STATUS, d);
    chk("status", 8'h96, d);
    ENABLE_I = 1'b0;
    cyc(8);
    CURRENT_LIMIT_I = 1'b0;
    chk("latch clear", 8'h00, {7'h0, LATCHOFF_O});
  endtask : t_run
  initial
  begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end
  initial
  begin
    #400000;
    n_fail++;
    $display("MISMATCH watchdog expected done seen hang");
    tally_and_finish();
  end
  initial
  begin
    SRST_I = 1'b1;
    ENABLE_I = 1'b0;
    SUPPLY_OK_I = 1'b1;
    CURRENT_LIMIT_I = 1'b0;
    VOLTAGE_CODE_I = 8'h00;
    PHASE_SENSE_I = 3'h0;
    // constant trip ends each pulse right after its turn
    PHASE_TRIP_I = 4'hf;
    cyc(16);
    SRST_I = 1'b0;
    cyc(4);
    t_regs();
    t_straps();
    t_sequence();
    t_run();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
